//--- rtl/ura_pkg.sv
// Package of the resume and attach sequencer: register map, field positions,
// reset values, link codes and timing figures.
// Assumes a UTMI transceiver whose output clock runs at 60 MHz.
package ura_pkg;

	// ---------------------------------------------------------------
	// Register map (byte addresses, one word each)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;

	// Control fields
	localparam int CTRL_ATTACH_EN = 0;
	localparam int CTRL_SUSP_REQ = 1;
	localparam int CTRL_HS_MODE = 2;
	localparam int CTRL_WAKE = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;

	// Status fields
	localparam int STAT_RUN = 0;
	localparam int STAT_SUSP = 1;
	localparam int STAT_SUSPENDN = 2;
	localparam int STAT_RESET_SEEN = 3;
	localparam int STAT_RESUME_SEEN = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ---------------------------------------------------------------
	// Link codes
	// ---------------------------------------------------------------
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;
	localparam logic [1:0] OPM_NORMAL = 2'h0;
	localparam logic [1:0] OPM_NODRIVE = 2'h1;
	localparam logic [1:0] OPM_RAW = 2'h2;

	// ---------------------------------------------------------------
	// Timing, in microseconds, clock rates in MHz and timer width in bits
	// ---------------------------------------------------------------
	localparam int LINK_MHZ = 60;
	localparam int CLK_MHZ = 100;
	localparam int T_WAKE_IDLE_US = 5000;
	localparam int T_ATTACH_US = 110000;
	localparam int T_DEBOUNCE_US = 110000;
	localparam int T_RESUME_K_US = 2000;
	localparam int T_RESUME_K_MAX_US = 15000;
	localparam int TMR_W = 24;

	typedef enum logic [3:0] {
		ST_OFF,
		ST_ATTACH_WAIT,
		ST_DEBOUNCE,
		ST_RUN,
		ST_SUSP,
		ST_DRIVE_K,
		ST_EOP_WAIT,
		ST_HOLD_K
	} ura_state_t;

endpackage : ura_pkg

//--- rtl/ura_sync.sv
// Two-flop level synchroniser, any width.
// Assumes each bit is a level or a toggle that holds for several target edges.
`timescale 1ns/1ps
`default_nettype none
module ura_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : ura_sync
`default_nettype wire

//--- rtl/ura_top.sv
// Engine-side sequencer for suspend exit, resume and attach on a UTMI link,
// with an AXI4-Lite slave for control and status.
// Assumes link_clk_i is the transceiver output clock and may stop in suspend.
//
// What this block does
// - Wait 5 ms bus idle before remote wake
// - Start resume K within 10 ms of wake
// - Resume K: raw opmode, FS, zero data
// - Stop driving K between 1 and 15 ms
// - Expect host SE0 ending the resume
// - FS device keeps FS selects after resume
// - Resume is FS; track J, K, SE0
// - Host resume K may release suspend early
// - Leave suspend on the J to K change
// - Normal mode within 1.25 us of SE0
// - FS device keeps FS terminations on resume
// - HS device switches terminations before SE0 ends
// - On attach select FS termination and transceiver
// - SE0 after debounce means bus reset
// - Attach and debounce each exceed 100 ms
`timescale 1ns/1ps
`default_nettype none
module ura_top
	import ura_pkg::*;
#(
	parameter int ATTACH_CYC = T_ATTACH_US * LINK_MHZ,
	parameter int DEBOUNCE_CYC = T_DEBOUNCE_US * LINK_MHZ,
	parameter int RESUME_K_CYC = T_RESUME_K_US * LINK_MHZ,
	parameter int WAKE_IDLE_CYC = T_WAKE_IDLE_US * CLK_MHZ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic [7:0] s_axil_awaddr_i,
	input wire logic s_axil_awvalid_i,
	output logic s_axil_awready_o,
	input wire logic [31:0] s_axil_wdata_i,
	input wire logic [3:0] s_axil_wstrb_i,
	input wire logic s_axil_wvalid_i,
	output logic s_axil_wready_o,
	output logic [1:0] s_axil_bresp_o,
	output logic s_axil_bvalid_o,
	input wire logic s_axil_bready_i,
	input wire logic [7:0] s_axil_araddr_i,
	input wire logic s_axil_arvalid_i,
	output logic s_axil_arready_o,
	output logic [31:0] s_axil_rdata_o,
	output logic [1:0] s_axil_rresp_o,
	output logic s_axil_rvalid_o,
	input wire logic s_axil_rready_i,
	input wire logic vbus_valid_i,
	input wire logic [1:0] linestate_i,
	output logic [1:0] opmode_o,
	output logic termselect_o,
	output logic xcvrselect_o,
	output logic txvalid_o,
	output logic [7:0] data_o,
	output logic suspendn_o
);
	localparam logic [TMR_W-1:0] ATTACH_LAST = TMR_W'(ATTACH_CYC - 1);
	localparam logic [TMR_W-1:0] DEBOUNCE_LAST = TMR_W'(DEBOUNCE_CYC - 1);
	localparam logic [TMR_W-1:0] RESUME_K_LAST = TMR_W'(RESUME_K_CYC - 1);
	localparam logic [TMR_W-1:0] WAKE_IDLE_LAST = TMR_W'(WAKE_IDLE_CYC - 1);
	localparam int K_MAX_CYC = T_RESUME_K_MAX_US * LINK_MHZ;

	// ---------------------------------------------------------------
	// Register bus (clk_i)
	// ---------------------------------------------------------------
	logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
	logic [7:0] awaddr_q;
	logic [7:0] wdata_q;
	logic wstrb0_q;
	logic [3:0] ctrl_q;
	logic reset_seen_q, resume_seen_q;
	logic wake_pend_q, wake_tgl_q, suspendn_q, released_q;
	logic [TMR_W-1:0] idle_cnt_q;
	logic [1:0] ls_s;
	logic [3:0] lstat_s;
	logic reset_tgl_seen_q, resume_tgl_seen_q;

	wire aw_take = s_axil_awvalid_i & s_axil_awready_o;
	wire w_take = s_axil_wvalid_i & s_axil_wready_o;
	wire wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
	wire ar_take = s_axil_arvalid_i & s_axil_arready_o;
	wire aw_hold_d = (aw_hold_q & ~wr_fire) | aw_take;
	wire w_hold_d = (w_hold_q & ~wr_fire) | w_take;
	wire bvalid_d = (bvalid_q & ~s_axil_bready_i) | wr_fire;
	wire rvalid_d = (rvalid_q & ~s_axil_rready_i) | ar_take;
	wire wr_ctrl = wr_fire & wstrb0_q & (awaddr_q == ADDR_CTRL);
	wire wr_stat = wr_fire & wstrb0_q & (awaddr_q == ADDR_STATUS);
	wire wr_hit = (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_STATUS);
	wire rd_ctrl = s_axil_araddr_i == ADDR_CTRL;
	wire rd_stat = s_axil_araddr_i == ADDR_STATUS;
	wire link_run_s = lstat_s[0];
	wire link_susp_s = lstat_s[1];
	wire reset_evt = lstat_s[2] ^ reset_tgl_seen_q;
	wire resume_evt = lstat_s[3] ^ resume_tgl_seen_q;
	wire idle_done = idle_cnt_q == WAKE_IDLE_LAST;
	wire wake_go = wake_pend_q & ~suspendn_q & idle_done;
	wire [31:0] ctrl_rd = {28'h0000_000, 1'b0, ctrl_q[2:0]};
	wire [31:0] stat_rd = {27'h000_0000, resume_seen_q, reset_seen_q, suspendn_q,
		link_susp_s, link_run_s};
	wire [31:0] rdata_d = rd_ctrl ? ctrl_rd : (rd_stat ? stat_rd : 32'h0000_0000);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			s_axil_awready_o <= 1'b0;
			s_axil_wready_o <= 1'b0;
			s_axil_arready_o <= 1'b0;
			s_axil_bvalid_o <= 1'b0;
			s_axil_rvalid_o <= 1'b0;
			s_axil_bresp_o <= RESP_OKAY;
			s_axil_rresp_o <= RESP_OKAY;
			s_axil_rdata_o <= 32'h0000_0000;
			awaddr_q <= 8'h00;
			wdata_q <= 8'h00;
			wstrb0_q <= 1'b0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			s_axil_awready_o <= ~aw_hold_d & ~bvalid_d;
			s_axil_wready_o <= ~w_hold_d & ~bvalid_d;
			s_axil_arready_o <= ~rvalid_d;
			s_axil_bvalid_o <= bvalid_d;
			s_axil_rvalid_o <= rvalid_d;
			if (aw_take) begin
				awaddr_q <= s_axil_awaddr_i;
			end
			if (w_take) begin
				wdata_q <= s_axil_wdata_i[7:0];
				wstrb0_q <= s_axil_wstrb_i[0];
			end
			if (wr_fire) begin
				s_axil_bresp_o <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (ar_take) begin
				s_axil_rdata_o <= rdata_d;
				s_axil_rresp_o <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ---------------------------------------------------------------
	// Control, status and suspend control (clk_i)
	// ---------------------------------------------------------------
	// Suspend control lives here because the link clock halts in suspend.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RESET;
			reset_seen_q <= 1'b0;
			resume_seen_q <= 1'b0;
			reset_tgl_seen_q <= 1'b0;
			resume_tgl_seen_q <= 1'b0;
			wake_pend_q <= 1'b0;
			wake_tgl_q <= 1'b0;
			suspendn_q <= 1'b1;
			released_q <= 1'b0;
			idle_cnt_q <= '0;
			suspendn_o <= 1'b1;
		end else begin
			reset_tgl_seen_q <= lstat_s[2];
			resume_tgl_seen_q <= lstat_s[3];
			if (wr_ctrl) begin
				ctrl_q <= {1'b0, wdata_q[2:0]};
			end
			// Set wins over a clear written in the same cycle
			reset_seen_q <= (reset_seen_q & ~(wr_stat & wdata_q[STAT_RESET_SEEN])) | reset_evt;
			resume_seen_q <= (resume_seen_q & ~(wr_stat & wdata_q[STAT_RESUME_SEEN]))
				| resume_evt;
			if (wake_go) begin
				wake_pend_q <= 1'b0;
			end else if (wr_ctrl & wdata_q[CTRL_WAKE]) begin
				wake_pend_q <= 1'b1;
			end
			if (!suspendn_q && ls_s == LS_J) begin
				idle_cnt_q <= idle_done ? idle_cnt_q : idle_cnt_q + 1'b1;
			end else begin
				idle_cnt_q <= '0;
			end
			if (!suspendn_q) begin
				if (ls_s == LS_K || wake_go) begin
					suspendn_q <= 1'b1;
					released_q <= 1'b1;
				end
				if (wake_go) begin
					wake_tgl_q <= ~wake_tgl_q;
				end
			end else if (link_susp_s && !released_q) begin
				suspendn_q <= 1'b0;
			end else if (!link_susp_s) begin
				released_q <= 1'b0;
			end
			suspendn_o <= suspendn_q;
		end
	end

	// ---------------------------------------------------------------
	// Crossings
	// ---------------------------------------------------------------
	logic rst_link_a_q, rst_link_q;
	logic [4:0] to_link_s;
	logic [3:0] lstat_q;
	logic [5:0] to_clk_s;

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_link_a_q <= 1'b1;
			rst_link_q <= 1'b1;
		end else begin
			rst_link_a_q <= 1'b0;
			rst_link_q <= rst_link_a_q;
		end
	end

	ura_sync #(.W(5)) u_sync_link (
		.clk_i(link_clk_i),
		.rst_i(rst_link_q),
		.d_i({vbus_valid_i, ctrl_q[2:0], wake_tgl_q}),
		.q_o(to_link_s)
	);

	ura_sync #(.W(6)) u_sync_clk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({linestate_i, lstat_q}),
		.q_o(to_clk_s)
	);
	assign ls_s = to_clk_s[5:4];
	assign lstat_s = to_clk_s[3:0];

	// ---------------------------------------------------------------
	// Link sequencer (link_clk_i)
	// ---------------------------------------------------------------
	ura_state_t state_q, state_d;
	logic [TMR_W-1:0] tmr_q;
	logic wake_seen_q, reset_tgl_q, resume_tgl_q;

	wire vbus_s = to_link_s[4];
	wire hs_s = to_link_s[CTRL_HS_MODE + 1];
	wire susp_req_s = to_link_s[CTRL_SUSP_REQ + 1];
	wire attach_en_s = to_link_s[CTRL_ATTACH_EN + 1];
	wire wake_evt = to_link_s[0] ^ wake_seen_q;
	wire ls_se0 = linestate_i == LS_SE0;
	wire attach_done = tmr_q == ATTACH_LAST;
	wire debounce_done = tmr_q == DEBOUNCE_LAST;
	wire k_done = tmr_q == RESUME_K_LAST;
	wire bus_reset = (state_q == ST_DEBOUNCE) & debounce_done & ls_se0;
	wire host_k = (state_q == ST_SUSP) & (linestate_i == LS_K) & ~wake_evt;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (vbus_s && attach_en_s) begin
					state_d = ST_ATTACH_WAIT;
				end
			end
			ST_ATTACH_WAIT: begin
				if (attach_done) begin
					state_d = ST_DEBOUNCE;
				end
			end
			ST_DEBOUNCE: begin
				if (debounce_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (susp_req_s) begin
					state_d = ST_SUSP;
				end
			end
			ST_SUSP: begin
				if (wake_evt) begin
					state_d = ST_DRIVE_K;
				end else if (linestate_i == LS_K) begin
					state_d = ST_HOLD_K;
				end
			end
			ST_DRIVE_K: begin
				if (k_done) begin
					state_d = ST_EOP_WAIT;
				end
			end
			ST_EOP_WAIT, ST_HOLD_K: begin
				if (ls_se0) begin
					state_d = ST_RUN;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		if (!vbus_s) begin
			state_d = ST_OFF;
		end
	end

	// Outputs decoded from the next state so they move with it
	wire run_d = state_d == ST_RUN;
	wire drive_k_d = state_d == ST_DRIVE_K;
	wire detached_d = (state_d == ST_OFF) | (state_d == ST_ATTACH_WAIT);
	wire fs_sel_d = ~(run_d & hs_s);
	wire [1:0] opmode_d = detached_d ? OPM_NODRIVE : (drive_k_d ? OPM_RAW : OPM_NORMAL);

	always_ff @(posedge link_clk_i or posedge rst_link_q) begin
		if (rst_link_q) begin
			state_q <= ST_OFF;
			tmr_q <= '0;
			wake_seen_q <= 1'b0;
			reset_tgl_q <= 1'b0;
			resume_tgl_q <= 1'b0;
			lstat_q <= 4'h0;
			opmode_o <= OPM_NODRIVE;
			termselect_o <= 1'b0;
			xcvrselect_o <= 1'b1;
			txvalid_o <= 1'b0;
			data_o <= 8'h00;
		end else begin
			state_q <= state_d;
			tmr_q <= (state_d == state_q) ? tmr_q + 1'b1 : '0;
			wake_seen_q <= to_link_s[0];
			reset_tgl_q <= reset_tgl_q ^ bus_reset;
			resume_tgl_q <= resume_tgl_q ^ host_k;
			lstat_q <= {resume_tgl_q, reset_tgl_q, state_q == ST_SUSP, state_q == ST_RUN};
			opmode_o <= opmode_d;
			termselect_o <= ~detached_d & fs_sel_d;
			xcvrselect_o <= fs_sel_d;
			txvalid_o <= drive_k_d;
			data_o <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [TMR_W-1:0] k_len_q;
	always_ff @(posedge link_clk_i or posedge rst_link_q) begin
		if (rst_link_q) begin
			k_len_q <= '0;
		end else begin
			k_len_q <= txvalid_o ? k_len_q + 1'b1 : '0;
		end
	end

	chk_wake_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(wake_tgl_q) |-> $past(idle_done) && !$past(suspendn_q))
		else $error("wake released before bus idle time");
	chk_wake_start: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		(state_q == ST_SUSP && wake_evt && vbus_s) |=> state_q == ST_DRIVE_K ##1 txvalid_o)
		else $error("resume K not started after wake");
	chk_k_pattern: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		txvalid_o |-> opmode_o == OPM_RAW && termselect_o && xcvrselect_o && data_o == 8'h00)
		else $error("resume K driven with wrong settings");
	chk_k_length: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		$fell(txvalid_o) && vbus_s |-> k_len_q == TMR_W'(RESUME_K_CYC)
		&& k_len_q < TMR_W'(K_MAX_CYC))
		else $error("resume K length out of range");
	chk_restore_mode: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		(state_q == ST_HOLD_K || state_q == ST_EOP_WAIT) && ls_se0 && vbus_s && $stable(hs_s)
		|=> state_q == ST_RUN && xcvrselect_o == !hs_s && termselect_o == !hs_s)
		else $error("normal mode not entered on resume SE0");
	chk_fs_keep: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		state_q == ST_RUN && !hs_s && !$past(hs_s) |-> termselect_o && xcvrselect_o)
		else $error("FS selects dropped in FS operation");
	chk_resume_fs: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		state_q == ST_SUSP || state_q == ST_HOLD_K |-> xcvrselect_o && termselect_o)
		else $error("suspend or resume not in FS");
	chk_attach_fs: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		state_q == ST_DEBOUNCE |-> termselect_o && xcvrselect_o && opmode_o == OPM_NORMAL)
		else $error("attach not signalled in FS");
	chk_attach_time: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		state_q == ST_ATTACH_WAIT && state_d == ST_DEBOUNCE |-> tmr_q == ATTACH_LAST)
		else $error("attach signalled early");
	chk_bus_reset: assert property (@(posedge link_clk_i) disable iff (rst_link_q)
		bus_reset |=> reset_tgl_q != $past(reset_tgl_q) && state_q == ST_RUN)
		else $error("bus reset not reported");
	chk_host_wake: assert property (@(posedge clk_i) disable iff (rst_i)
		!suspendn_q && ls_s == LS_K |=> suspendn_q ##1 suspendn_o)
		else $error("suspend not left on K");
endmodule : ura_top
`default_nettype wire

//--- tb/ura_xcvr_model.sv
// Transceiver model at the far side of the link: output clock and line state.
// Assumes the bench plays the host port through host_drv_i and host_st_i.
`timescale 1ns/1ps
`default_nettype none
module ura_xcvr_model
	import ura_pkg::*;
(
	input wire logic suspendn_i,
	input wire logic [1:0] opmode_i,
	input wire logic termselect_i,
	input wire logic txvalid_i,
	input wire logic host_drv_i,
	input wire logic [1:0] host_st_i,
	output logic clkout_o,
	output logic [1:0] linestate_o
);
	// ------------------------------------------------------------
	// Output clock, stands still while suspended
	// ------------------------------------------------------------
	initial begin
		clkout_o = 1'b0;
		forever #24 if (suspendn_i === 1'b1) clkout_o = ~clkout_o;
	end

	// ------------------------------------------------------------
	// Line: raw transmit forces K, else host, else pull-up
	// ------------------------------------------------------------
	wire logic drive_k = txvalid_i && (opmode_i == OPM_RAW);
	wire logic [1:0] idle_st = termselect_i ? LS_J : LS_SE0;
	assign linestate_o = drive_k ? LS_K : (host_drv_i ? host_st_i : idle_st);
endmodule : ura_xcvr_model
`default_nettype wire

//--- tb/ura_top_test.sv
// Self-checking bench of the resume and attach sequencer.
// Assumes short timing parameters; the model makes the link clock.
`timescale 1ns/1ps
`default_nettype none
module ura_top_test
	import ura_pkg::*;
;
	localparam int AT = 200;
	localparam int DB = 200;
	localparam int RK = 50;
	localparam int WI = 100;
	logic clk_i = 1'b0;
	logic rst_i, vbus, host_drv, awvalid, wvalid, bready, arvalid, rready;
	logic [1:0] host_st, bresp, rresp, opmode, rsp;
	logic [7:0] awaddr, araddr, data;
	logic [31:0] wdata, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid, termsel, xcvrsel, txvalid, suspendn;
	wire logic link_clk;
	wire logic [1:0] ls;
	int num_errors, comparisons, n;
	time t0;

	ura_top #(.ATTACH_CYC(AT), .DEBOUNCE_CYC(DB), .RESUME_K_CYC(RK), .WAKE_IDLE_CYC(WI)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
		.s_axil_awaddr_i(awaddr), .s_axil_awvalid_i(awvalid), .s_axil_awready_o(awready),
		.s_axil_wdata_i(wdata), .s_axil_wstrb_i(4'hF), .s_axil_wvalid_i(wvalid),
		.s_axil_wready_o(wready), .s_axil_bresp_o(bresp), .s_axil_bvalid_o(bvalid),
		.s_axil_bready_i(bready), .s_axil_araddr_i(araddr), .s_axil_arvalid_i(arvalid),
		.s_axil_arready_o(arready), .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp),
		.s_axil_rvalid_o(rvalid), .s_axil_rready_i(rready), .vbus_valid_i(vbus),
		.linestate_i(ls), .opmode_o(opmode), .termselect_o(termsel), .xcvrselect_o(xcvrsel),
		.txvalid_o(txvalid), .data_o(data), .suspendn_o(suspendn));
	ura_xcvr_model xcvr (.suspendn_i(suspendn), .opmode_i(opmode), .termselect_i(termsel),
		.txvalid_i(txvalid), .host_drv_i(host_drv), .host_st_i(host_st),
		.clkout_o(link_clk), .linestate_o(ls));

	always #5 clk_i = ~clk_i;

	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report;
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// A used-up wait bound is a failure
	task automatic limit(input int k, input int lim);
		if (k >= lim) begin
			check(k, 0);
			final_report();
		end
	endtask : limit

	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		int k;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		k = 0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok) && k < 100) begin
			@(posedge clk_i);
			k++;
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (k < 100 && bvalid !== 1'b1) begin
			@(posedge clk_i);
			k++;
		end
		limit(k, 100);
		rsp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			k++;
		end while (k < 100 && arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
		end while (k < 100 && rvalid !== 1'b1);
		limit(k, 100);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Link edges seen from clk_i; a stopped link clock cannot hang it
	task automatic lwait(input int k);
		int c, i;
		logic prev;
		c = 0;
		prev = link_clk;
		for (i = 0; i < 20 * k && c < k; i++) begin
			@(posedge clk_i);
			c += (link_clk === 1'b1 && prev !== 1'b1) ? 1 : 0;
			prev = link_clk;
		end
		limit(k - c, 1);
	endtask : lwait

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		vbus = 1'b1;
		host_drv = 1'b1;
		host_st = LS_SE0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0000_0000;
		rd = 32'h0000_0000;
		num_errors = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		lwait(4);
		check({opmode, termsel}, {OPM_NODRIVE, 1'b0});
		axi_rd(ADDR_CTRL);
		check(rd, CTRL_RESET);
		axi_rd(8'h08);
		check(rsp, RESP_SLVERR);
		axi_wr(8'h0C, 32'h0000_0001);
		check(rsp, RESP_SLVERR);
		// Attach with host holding SE0, so the debounce end sees a bus reset
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		t0 = $time;
		for (n = 0; n < 5000 && termsel !== 1'b1; n++) @(posedge clk_i);
		limit(n, 5000);
		check($time - t0 >= AT * 48, 1);
		check({xcvrsel, txvalid}, 2'h2);
		t0 = $time;
		for (n = 0; n < 2000 && rd[STAT_RESET_SEEN] !== 1'b1; n++) axi_rd(ADDR_STATUS);
		limit(n, 2000);
		check($time - t0 >= DB * 48, 1);
		check(rd[STAT_RUN], 1);
		host_drv <= 1'b0;
		check({opmode, termsel, xcvrsel}, {OPM_NORMAL, 2'h3});
		axi_wr(ADDR_STATUS, 32'h0000_0008);
		axi_rd(ADDR_STATUS);
		check(rd[STAT_RESET_SEEN], 0);
		// Suspend, then remote wake
		axi_wr(ADDR_CTRL, 32'h0000_0003);
		for (n = 0; n < 500 && suspendn !== 1'b0; n++) @(posedge clk_i);
		limit(n, 500);
		t0 = $time;
		axi_wr(ADDR_CTRL, 32'h0000_000B);
		for (n = 0; n < 2000 && suspendn !== 1'b1; n++) @(posedge clk_i);
		limit(n, 2000);
		check($time - t0 >= (WI - 8) * 10, 1);
		for (n = 0; n < 2000 && txvalid !== 1'b1; n++) @(posedge clk_i);
		limit(n, 2000);
		check({opmode, termsel, xcvrsel, data, ls}, {OPM_RAW, 2'h3, 8'h00, LS_K});
		host_st <= LS_K;
		host_drv <= 1'b1;
		for (n = 0; n < 5000 && txvalid === 1'b1; n++) @(posedge clk_i);
		check(n * 10 >= (RK - 1) * 48 && n * 10 <= (RK + 1) * 48, 1);
		axi_wr(ADDR_CTRL, 32'h0000_0001);
		check({txvalid, opmode}, {1'b0, OPM_NORMAL});
		host_st <= LS_SE0;
		lwait(3);
		check({opmode, termsel, xcvrsel}, {OPM_NORMAL, 2'h3});
		host_drv <= 1'b0;
		// HS device suspended, host resume
		axi_wr(ADDR_CTRL, 32'h0000_0007);
		for (n = 0; n < 500 && suspendn !== 1'b0; n++) @(posedge clk_i);
		limit(n, 500);
		host_st <= LS_K;
		host_drv <= 1'b1;
		for (n = 0; n < 200 && suspendn !== 1'b1; n++) @(posedge clk_i);
		limit(n, 200);
		axi_wr(ADDR_CTRL, 32'h0000_0005);
		lwait(4);
		check({txvalid, termsel, xcvrsel}, 3'h3);
		host_st <= LS_SE0;
		lwait(3);
		check({opmode, termsel, xcvrsel}, {OPM_NORMAL, 2'h0});
		host_drv <= 1'b0;
		axi_rd(ADDR_STATUS);
		check(rd[STAT_RESUME_SEEN], 1);
		// Loss of bus power
		vbus <= 1'b0;
		lwait(6);
		check({opmode, termsel}, {OPM_NODRIVE, 1'b0});
		final_report();
	end
endmodule : ura_top_test
`default_nettype wire
